// ### fcva_map.vh
`ifndef FCVA_MAP_VH
`define FCVA_MAP_VH

// ***************************************************
// register addresses on the host write port
// ***************************************************
`define FCVA_ADDR_DIRECT 5'h0b
`define FCVA_ADDR_INT    5'h0f
`define FCVA_ADDR_FRAC   5'h10
`define FCVA_ADDR_SEED   5'h11

// ***************************************************
// widths, resets and counts
// ***************************************************
`define FCVA_INT_W       16
`define FCVA_FRAC_W      24
`define FCVA_DIRECT_W    10
`define FCVA_CAP_W       5
`define FCVA_PRE_W       5
`define FCVA_CNT_W       32
`define FCVA_WIN_W       20
`define FCVA_CNT_SHIFT   30
`define FCVA_FRAME_W     16
`define FCVA_INT_RST     16'h0040
`define FCVA_ERR_MAX     32'hffffffff

`endif

// ### fcva_sync.v
`timescale 1ns/1ps
`default_nettype none

// ***************************************************
// two flop synchroniser
// ***************************************************
module fcva_sync
(
    input  wire clk_in,
    input  wire rst_in,
    input  wire d_in,
    output reg  q_out
);

    reg         meta_r;

    // first flop read only by the second
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_r <= 1'b0;
            q_out  <= 1'b0;
        end
        else
        begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end

endmodule // fcva_sync

`default_nettype wire

// ### fcva_vspi.v
`timescale 1ns/1ps
`default_nettype none
`include "fcva_map.vh"

// ***************************************************
// vco three wire serial write
// ***************************************************
module fcva_vspi
#(
    parameter DATA_W  = `FCVA_DIRECT_W,
    parameter FRAME_W = `FCVA_FRAME_W,
    parameter [FRAME_W-DATA_W-1:0] VCO_ADDR = 0
)
(
    input  wire              clk_in,
    input  wire              rst_in,
    input  wire              start_in,
    input  wire [DATA_W-1:0] data_in,
    output wire              busy_out,
    output reg               done_out,
    output reg               sclk_out,
    output reg               sdata_out,
    output reg               sen_out
);

    reg [FRAME_W-1:0] shift_r;
    reg [4:0]         bits_r;
    reg               act_r;
    reg               phase_r;

    assign busy_out = act_r;

    // one bit per two clocks, data changes while clock low
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            shift_r   <= {FRAME_W{1'b0}};
            bits_r    <= 5'h00;
            act_r     <= 1'b0;
            phase_r   <= 1'b0;
            done_out  <= 1'b0;
            sclk_out  <= 1'b0;
            sdata_out <= 1'b0;
            sen_out   <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            if (!act_r)
            begin
                sclk_out <= 1'b0;
                sen_out  <= 1'b0;
                if (start_in)
                begin
                    shift_r   <= {VCO_ADDR, data_in};
                    sdata_out <= VCO_ADDR[FRAME_W-DATA_W-1];
                    bits_r    <= FRAME_W[4:0];
                    act_r     <= 1'b1;
                    phase_r   <= 1'b0;
                    sen_out   <= 1'b1;
                end
            end
            else if (!phase_r)
            begin
                sclk_out  <= 1'b1;   // vco samples a settled bit
                phase_r   <= 1'b1;
            end
            else
            begin
                sclk_out  <= 1'b0;
                sdata_out <= shift_r[FRAME_W-2];   // next bit, clock low
                phase_r   <= 1'b0;
                shift_r  <= {shift_r[FRAME_W-2:0], 1'b0};
                bits_r   <= bits_r - 5'h01;
                if (bits_r == 5'h01)
                begin
                    act_r    <= 1'b0;   // vco latched on last rising edge
                    sen_out  <= 1'b0;
                    done_out <= 1'b1;
                end
            end
        end
    end

endmodule // fcva_vspi

`default_nettype wire

// ### fcva_top.v
`timescale 1ns/1ps
`default_nettype none
`include "fcva_map.vh"

// ***************************************************
// frequency change and vco calibration
// ***************************************************
module fcva_top
(
    input  wire                      CLK_IN,
    input  wire                      RST_IN,
    input  wire                      WR_STB_IN,
    input  wire [4:0]                WR_ADDR_IN,
    input  wire [23:0]               WR_DATA_IN,
    input  wire                      INT_MODE_IN,
    input  wire                      AUTOSEED_IN,
    input  wire                      AUTO_START_IN,
    input  wire                      MAN_START_IN,
    input  wire                      STEP_VCO_IN,
    input  wire                      INVERT_IN,
    input  wire [3:0]                NCYC_IN,
    input  wire [1:0]                XREFDIV_IN,
    input  wire                      VCO_DIV_IN,
    output reg  [`FCVA_INT_W-1:0]    PRESC_INT_OUT,
    output reg  [`FCVA_FRAC_W-1:0]   ACT_FRAC_OUT,
    output reg                       ACC_LOAD_OUT,
    output reg  [`FCVA_FRAC_W-1:0]   ACC_SEED_OUT,
    output reg                       FREQ_STB_OUT,
    output reg  [`FCVA_DIRECT_W-1:0] DIRECT_DATA_OUT,
    output reg  [7:0]                CAL_RESULT_OUT,
    output reg  [`FCVA_CNT_W-1:0]    CAL_COUNT_OUT,
    output wire                      BUSY_OUT,
    output wire                      TUNE_MID_OUT,
    output wire                      VCO_SCLK_OUT,
    output wire                      VCO_SDATA_OUT,
    output wire                      VCO_SEN_OUT
);

    // ***************************************************
    // states
    // ***************************************************
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_SEND  = 3'h1;
    localparam [2:0] ST_SENDW = 3'h2;
    localparam [2:0] ST_MEAS  = 3'h3;
    localparam [2:0] ST_EVAL  = 3'h4;
    localparam [2:0] ST_FINAL = 3'h5;
    localparam [2:0] ST_FINW  = 3'h6;
    localparam [2:0] ST_DIRW  = 3'h7;

    localparam CW = `FCVA_CAP_W;
    localparam DW = `FCVA_DIRECT_W;

    // ***************************************************
    // declarations
    // ***************************************************
    reg  [`FCVA_INT_W-1:0]  buf_int_r;
    reg  [`FCVA_FRAC_W-1:0] buf_seed_r;
    reg  [2:0]              state_r;
    reg  [CW-1:0]           code_r;
    reg  [2:0]              bitpos_r;
    reg  [CW-1:0]           best_code_r;
    reg  [`FCVA_CNT_W-1:0]  best_err_r;
    reg                     final_r;
    reg                     manual_r;
    reg  [`FCVA_WIN_W-1:0]  win_cnt_r;
    reg  [`FCVA_PRE_W-1:0]  pre_cnt_r;
    reg  [`FCVA_CNT_W-1:0]  edge_cnt_r;
    reg                     vco_last_r;
    reg                     spi_start;
    reg  [DW-1:0]           spi_data;
    reg                     cal_done;
    reg  [CW-1:0]           sar_code;
    wire                    vco_sync;
    wire                    vco_edge;
    wire                    spi_busy;
    wire                    spi_done;
    wire                    wr_int;
    wire                    wr_frac;
    wire                    freq_chg;
    wire                    launch;
    wire [4:0]              win_exp;
    wire [`FCVA_WIN_W-1:0]  win_len;
    wire [63:0]             n_ext;
    wire [63:0]             tgt_full;
    wire [`FCVA_CNT_W-1:0]  tgt;
    wire [`FCVA_CNT_W-1:0]  err;
    wire [CW-1:0]           cur_bit;
    wire [CW-1:0]           best_tuned;
    wire [CW-1:0]           code_tuned;

    // ***************************************************
    // change event decode
    // ***************************************************
    assign wr_int   = WR_STB_IN && (WR_ADDR_IN == `FCVA_ADDR_INT);
    assign wr_frac  = WR_STB_IN && (WR_ADDR_IN == `FCVA_ADDR_FRAC);
    assign freq_chg = (wr_frac && !INT_MODE_IN)
                   || (wr_int && INT_MODE_IN);
    // calibration requests, honoured only when idle
    assign launch   = STEP_VCO_IN && ((freq_chg && AUTO_START_IN)
                   || MAN_START_IN);

    // host buffers, not yet active
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            buf_int_r  <= `FCVA_INT_RST;
            buf_seed_r <= {`FCVA_FRAC_W{1'b0}};
        end
        else
        begin
            if (wr_int)
                buf_int_r <= WR_DATA_IN[`FCVA_INT_W-1:0];
            if (WR_STB_IN && (WR_ADDR_IN == `FCVA_ADDR_SEED))
                buf_seed_r <= WR_DATA_IN;
        end
    end

    // active values move only on a change event
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            PRESC_INT_OUT <= `FCVA_INT_RST;
            ACT_FRAC_OUT  <= {`FCVA_FRAC_W{1'b0}};
            ACC_LOAD_OUT  <= 1'b0;
            ACC_SEED_OUT  <= {`FCVA_FRAC_W{1'b0}};
            FREQ_STB_OUT  <= 1'b0;
        end
        else
        begin
            FREQ_STB_OUT <= freq_chg;
            ACC_LOAD_OUT <= freq_chg && AUTOSEED_IN;
            if (freq_chg)
            begin
                // integer value taken from the write itself on an integer write, else from buf_int_r
                PRESC_INT_OUT <= wr_int ? WR_DATA_IN[`FCVA_INT_W-1:0]
                                        : buf_int_r;
                if (!INT_MODE_IN)
                    ACT_FRAC_OUT <= WR_DATA_IN;
                else
                    ACT_FRAC_OUT <= {`FCVA_FRAC_W{1'b0}};
                if (AUTOSEED_IN)
                    ACC_SEED_OUT <= buf_seed_r;
            end
        end
    end

    // ***************************************************
    // measurement path
    // ***************************************************
    fcva_sync u_vsync
    (
        .clk_in (CLK_IN),
        .rst_in (RST_IN),
        .d_in   (VCO_DIV_IN),
        .q_out  (vco_sync)
    );

    assign vco_edge = vco_sync && !vco_last_r;
    assign win_exp  = {1'b0, NCYC_IN} + {3'h0, XREFDIV_IN};
    assign win_len  = {{(`FCVA_WIN_W-1){1'b0}}, 1'b1} << win_exp;
    // expected count of the programmed ratio over one window
    assign n_ext    = {24'h000000, PRESC_INT_OUT, ACT_FRAC_OUT};
    assign tgt_full = n_ext << win_exp;
    assign tgt      = tgt_full[`FCVA_CNT_SHIFT+`FCVA_CNT_W-1:
                               `FCVA_CNT_SHIFT];
    assign err      = (edge_cnt_r > tgt) ? (edge_cnt_r - tgt)
                                         : (tgt - edge_cnt_r);

    // divide by 32, count carries inside window
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            vco_last_r <= 1'b0;
            pre_cnt_r  <= {`FCVA_PRE_W{1'b0}};
            edge_cnt_r <= {`FCVA_CNT_W{1'b0}};
            win_cnt_r  <= {`FCVA_WIN_W{1'b0}};
        end
        else
        begin
            vco_last_r <= vco_sync;
            if (state_r != ST_MEAS)
            begin
                pre_cnt_r <= {`FCVA_PRE_W{1'b0}};
                win_cnt_r <= {`FCVA_WIN_W{1'b0}};
                if (state_r == ST_SENDW)
                    edge_cnt_r <= {`FCVA_CNT_W{1'b0}};
            end
            else
            begin
                win_cnt_r <= win_cnt_r + {{(`FCVA_WIN_W-1){1'b0}}, 1'b1};
                if (vco_edge)
                begin
                    pre_cnt_r <= pre_cnt_r + {{(`FCVA_PRE_W-1){1'b0}}, 1'b1};
                    if (&pre_cnt_r)
                        edge_cnt_r <= edge_cnt_r + 32'h1;
                end
            end
        end
    end

    // ***************************************************
    // search state machine
    // ***************************************************
    assign cur_bit    = {{(CW-1){1'b0}}, 1'b1} << bitpos_r;
    assign code_tuned = INVERT_IN ? ~code_r : code_r;
    assign best_tuned = INVERT_IN ? ~best_code_r : best_code_r;
    assign BUSY_OUT   = (state_r != ST_IDLE) && (state_r != ST_DIRW);
    assign TUNE_MID_OUT = BUSY_OUT;

    // serial request and next trial code
    always @*
    begin
        spi_start = 1'b0;
        spi_data  = DIRECT_DATA_OUT;
        sar_code  = (edge_cnt_r > tgt) ? code_r : (code_r & ~cur_bit);
        cal_done  = (state_r == ST_FINW) && spi_done;
        case (state_r)
            ST_IDLE, ST_DIRW:
            begin
                // direct switch data on a change event, dropped if the port is busy
                spi_start = freq_chg && STEP_VCO_IN && !launch
                         && !spi_busy;
            end
            ST_SEND:
            begin
                spi_start = 1'b1;
                spi_data  = {DIRECT_DATA_OUT[DW-1:CW], code_tuned};
            end
            ST_FINAL:
            begin
                spi_start = 1'b1;
                spi_data  = {DIRECT_DATA_OUT[DW-1:CW], best_tuned};
            end
            default:
            begin
                spi_start = 1'b0;
            end
        endcase
    end

    // calibration sequencing
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            state_r     <= ST_IDLE;
            code_r      <= {CW{1'b0}};
            bitpos_r    <= 3'h0;
            best_code_r <= {CW{1'b0}};
            best_err_r  <= `FCVA_ERR_MAX;
            final_r     <= 1'b0;
            manual_r    <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE, ST_DIRW:
                begin
                    // a frame still shifting blocks every request
                    if (spi_busy)
                        state_r <= ST_DIRW;
                    else if (launch)
                    begin
                        manual_r    <= !(freq_chg && AUTO_START_IN);
                        code_r      <= {1'b1, {(CW-1){1'b0}}};
                        bitpos_r    <= CW[2:0] - 3'h1;
                        best_err_r  <= `FCVA_ERR_MAX;
                        final_r     <= 1'b0;
                        state_r     <= ST_SEND;
                    end
                    else if (spi_start)
                        state_r <= ST_DIRW;
                    else
                        state_r <= ST_IDLE;
                end
                ST_SEND:
                    state_r <= ST_SENDW;
                ST_SENDW:
                    if (spi_done)
                        state_r <= ST_MEAS;
                ST_MEAS:
                    if (win_cnt_r == win_len - 20'h00001)
                        state_r <= ST_EVAL;
                ST_EVAL:
                begin
                    // keep nearest measured setting
                    if (err < best_err_r)
                    begin
                        best_err_r  <= err;
                        best_code_r <= code_r;
                    end
                    if (final_r)
                        state_r <= ST_FINAL;
                    else if (bitpos_r == 3'h0)
                    begin
                        if (sar_code == code_r)
                            state_r <= ST_FINAL;
                        else
                        begin
                            code_r  <= sar_code;
                            final_r <= 1'b1;
                            state_r <= ST_SEND;
                        end
                    end
                    else
                    begin
                        code_r   <= sar_code | (cur_bit >> 1);
                        bitpos_r <= bitpos_r - 3'h1;
                        state_r  <= ST_SEND;
                    end
                end
                ST_FINAL:
                    state_r <= ST_FINW;
                ST_FINW:
                    if (spi_done)
                        state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ***************************************************
    // result and direct data registers
    // ***************************************************
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            DIRECT_DATA_OUT <= {DW{1'b0}};
            CAL_RESULT_OUT  <= 8'h00;
            CAL_COUNT_OUT   <= {`FCVA_CNT_W{1'b0}};
        end
        else
        begin
            if (state_r == ST_EVAL)
                CAL_COUNT_OUT <= edge_cnt_r;
            if (cal_done)
                CAL_RESULT_OUT <= {{(8-CW){1'b0}}, best_tuned};
            // calibration write wins over a host write
            if (cal_done && manual_r)
                DIRECT_DATA_OUT <= {DIRECT_DATA_OUT[DW-1:CW], best_tuned};
            else if (WR_STB_IN && (WR_ADDR_IN == `FCVA_ADDR_DIRECT))
                DIRECT_DATA_OUT <= WR_DATA_IN[DW-1:0];
        end
    end

    // ***************************************************
    // vco serial port
    // ***************************************************
    fcva_vspi u_vspi
    (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN),
        .start_in  (spi_start),
        .data_in   (spi_data),
        .busy_out  (spi_busy),
        .done_out  (spi_done),
        .sclk_out  (VCO_SCLK_OUT),
        .sdata_out (VCO_SDATA_OUT),
        .sen_out   (VCO_SEN_OUT)
    );

endmodule // fcva_top

`default_nettype wire

// ### fcva_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcva_map.vh"
// ***************************************************
// checker for frequency change and calibration
// ***************************************************
module fcva_properties
(
    input wire logic                    CLK_IN,
    input wire logic                    RST_IN,
    input wire logic                    WR_STB_IN,
    input wire logic [4:0]              WR_ADDR_IN,
    input wire logic [23:0]             WR_DATA_IN,
    input wire logic                    INT_MODE_IN,
    input wire logic                    AUTOSEED_IN,
    input wire logic                    AUTO_START_IN,
    input wire logic                    MAN_START_IN,
    input wire logic                    STEP_VCO_IN,
    input wire logic [`FCVA_INT_W-1:0]  PRESC_INT_OUT,
    input wire logic [`FCVA_FRAC_W-1:0] ACT_FRAC_OUT,
    input wire logic                    ACC_LOAD_OUT,
    input wire logic                    FREQ_STB_OUT,
    input wire logic                    BUSY_OUT,
    input wire logic                    TUNE_MID_OUT,
    input wire logic                    VCO_SEN_OUT
);
    wire chg_frac;
    wire chg_int;
    // change events seen at the write port
    assign chg_frac = WR_STB_IN && WR_ADDR_IN == 5'h10 && !INT_MODE_IN;
    assign chg_int  = WR_STB_IN && WR_ADDR_IN == 5'h0f && INT_MODE_IN;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // launch allowed: idle, no frame running, vco present
    sequence launch_ok;
        !BUSY_OUT && !VCO_SEN_OUT && STEP_VCO_IN;
    endsequence
    // enable high on the first 8 cycles and on the 32nd, then low on the next
    sequence frame_body;
        VCO_SEN_OUT [*8] ##24 VCO_SEN_OUT ##1 !VCO_SEN_OUT;
    endsequence
    freq_stb_cause_a: assert property (FREQ_STB_OUT |-> $past(chg_frac || chg_int))
        else $error("change strobe without trigger write");
    frac_change_a: assert property (chg_frac |=> FREQ_STB_OUT
        && ACT_FRAC_OUT == $past(WR_DATA_IN)) else $error("frac change lost");
    int_change_a: assert property (chg_int |=> FREQ_STB_OUT && ACT_FRAC_OUT == 0
        && PRESC_INT_OUT == $past(WR_DATA_IN[15:0])) else $error("int change lost");
    presc_hold_a: assert property (!FREQ_STB_OUT && !$past(RST_IN)
        |-> $stable(PRESC_INT_OUT)) else $error("ratio moved without change");
    seed_load_a: assert property (FREQ_STB_OUT |-> ACC_LOAD_OUT == $past(AUTOSEED_IN))
        else $error("seed load mismatch");
    tune_mid_a: assert property (TUNE_MID_OUT == BUSY_OUT)
        else $error("tuning hold differs from busy");
    auto_launch_a: assert property ((chg_frac || chg_int) && AUTO_START_IN ##0 launch_ok
        |=> BUSY_OUT) else $error("auto calibration not launched");
    direct_send_a: assert property ((chg_frac || chg_int) && !AUTO_START_IN
        && !MAN_START_IN ##0 launch_ok |=> VCO_SEN_OUT) else $error("no direct frame");
    manual_launch_a: assert property (MAN_START_IN && !AUTO_START_IN ##0 launch_ok
        |=> BUSY_OUT) else $error("manual calibration not launched");
    frame_len_a: assert property ($rose(VCO_SEN_OUT) |-> frame_body)
        else $error("serial frame length wrong");
    busy_span_a: assert property ($rose(BUSY_OUT) |-> BUSY_OUT [*8] ##30 BUSY_OUT)
        else $error("busy dropped early");
endmodule // fcva_properties

bind fcva_top fcva_properties u_props (.CLK_IN, .RST_IN, .WR_STB_IN, .WR_ADDR_IN,
    .WR_DATA_IN, .INT_MODE_IN, .AUTOSEED_IN, .AUTO_START_IN, .MAN_START_IN,
    .STEP_VCO_IN, .PRESC_INT_OUT, .ACT_FRAC_OUT, .ACC_LOAD_OUT, .FREQ_STB_OUT,
    .BUSY_OUT, .TUNE_MID_OUT, .VCO_SEN_OUT);
`default_nettype wire

// ### fcva_vco_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// step tuned vco with three wire port
// ***************************************************
module fcva_vco_model
(
    input  wire logic        sclk_in,
    input  wire logic        sdata_in,
    input  wire logic        sen_in,
    output var  logic        vco_div_out,
    output var  logic [15:0] word_out,
    output var  int          frames_out
);
    logic [15:0] shift_r;
    int          bits_r;
    initial
    begin
        vco_div_out = 1'b0;
        word_out = 16'h0000;
        frames_out = 0;
        shift_r = 16'h0000;
        bits_r = 0;
    end
    // free running divided output, bigger code runs slower
    always #((30.0 + word_out[4:0]) / 2.0) vco_div_out = ~vco_div_out;
    // a new frame starts when enable drops
    always @(negedge sen_in) bits_r = 0;
    // shift msb first, latch on the sixteenth clock rise
    always @(posedge sclk_in)
    if (sen_in)
    begin
        shift_r = {shift_r[14:0], sdata_in};
        bits_r++;
        if (bits_r == 16)
        begin
            word_out = shift_r;
            frames_out++;
        end
    end
endmodule // fcva_vco_model
`default_nettype wire

// ### fcva_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// testbench for frequency change and calibration
// ***************************************************
module fcva_top_tb_top;
    logic        clk, rst, wr_stb, int_mode, autoseed, auto_start, man_start;
    logic        step_vco, invert;
    logic [4:0]  wr_addr;
    logic [23:0] wr_data;
    logic [3:0]  ncyc;
    wire  [15:0] presc, vco_word;
    wire  [23:0] act_frac, acc_seed;
    wire  [9:0]  direct;
    wire  [7:0]  cal_res;
    wire  [31:0] cal_cnt;
    wire         acc_load, freq_stb, busy, tune_mid, sclk, sdata, sen, vco_div;
    int          frames, f0, i;
    int          n_errors = 0;
    int          checked = 0;
    fcva_top u_dut (.CLK_IN(clk), .RST_IN(rst), .WR_STB_IN(wr_stb),
        .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data), .INT_MODE_IN(int_mode),
        .AUTOSEED_IN(autoseed), .AUTO_START_IN(auto_start),
        .MAN_START_IN(man_start), .STEP_VCO_IN(step_vco), .INVERT_IN(invert),
        .NCYC_IN(ncyc), .XREFDIV_IN(2'b00), .VCO_DIV_IN(vco_div),
        .PRESC_INT_OUT(presc), .ACT_FRAC_OUT(act_frac), .ACC_LOAD_OUT(acc_load),
        .ACC_SEED_OUT(acc_seed), .FREQ_STB_OUT(freq_stb),
        .DIRECT_DATA_OUT(direct), .CAL_RESULT_OUT(cal_res),
        .CAL_COUNT_OUT(cal_cnt), .BUSY_OUT(busy), .TUNE_MID_OUT(tune_mid),
        .VCO_SCLK_OUT(sclk), .VCO_SDATA_OUT(sdata), .VCO_SEN_OUT(sen));
    fcva_vco_model u_vco (.sclk_in(sclk), .sdata_in(sdata), .sen_in(sen),
        .vco_div_out(vco_div), .word_out(vco_word), .frames_out(frames));
    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // ***************************************************
    // tasks
    // ***************************************************
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // idle edge, then one cycle write pulse; returns in the answer cycle
    task wr(input logic [4:0] a, input logic [23:0] d);
        cyc(1);
        wr_stb = 1'b1;
        wr_addr = a;
        wr_data = d;
        cyc(1);
        wr_stb = 1'b0;
    endtask
    task wait_idle;
        i = 0;
        cyc(2);
        while (busy !== 1'b0 && i < 30000)
        begin
            cyc(1);
            i++;
        end
        chk(i < 30000, 1);
    endtask
    // count of the model for a code against target 8
    function logic near(input logic [4:0] c);
        int n;
        n = 320 / (30 + c);
        return (n >= 7) && (n <= 9);
    endfunction
    task summarize;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog well past the expected run time
    initial
    begin
        #400000;
        n_errors++;
        summarize;
    end
    // ***************************************************
    // tests
    // ***************************************************
    initial
    begin
        rst = 1'b1; wr_stb = 1'b0; wr_addr = 5'h00; wr_data = 24'h000000;
        int_mode = 1'b0; autoseed = 1'b1; auto_start = 1'b0;
        man_start = 1'b0; step_vco = 1'b1; ncyc = 4'ha;
        invert = 1'b0;
        cyc(20);
        rst = 1'b0;
        chk(presc, 16'h0040);
        chk({tune_mid, busy}, 2'b00);
        chk(act_frac, 24'h000000);
        $display("test reset done");
        wr(5'h11, 24'h00abcd);
        wr(5'h0b, 24'h000155);
        wr(5'h0f, 24'h000123);
        chk({freq_stb, presc}, 24'h000040);
        wr(5'h10, 24'h345678);
        chk({freq_stb, acc_load, presc}, 24'h030123);
        chk(act_frac, 24'h345678);
        chk(acc_seed, 24'h00abcd);
        cyc(40);
        chk(vco_word, 16'h0155);
        $display("test frac mode done");
        int_mode = 1'b1;
        wr(5'h10, 24'h111111);
        chk(freq_stb, 1'b0);
        chk(act_frac, 24'h345678);
        wr(5'h0f, 24'h000077);
        chk({freq_stb, presc}, 24'h010077);
        chk(act_frac, 24'h000000);
        cyc(40);
        int_mode = 1'b0;
        $display("test int mode done");
        auto_start = 1'b1;
        wr(5'h0f, 24'h000000);
        f0 = frames;
        wr(5'h10, 24'h800000);
        cyc(2);
        chk({busy, tune_mid}, 2'b11);
        cyc(100);
        wr(5'h10, 24'h800000);
        wait_idle;
        chk((frames - f0 == 6) || (frames - f0 == 7), 1);
        chk(cal_res, {3'h0, vco_word[4:0]});
        chk(near(vco_word[4:0]), 1);
        chk(vco_word[9:5], direct[9:5]);
        auto_start = 1'b0;
        $display("test auto cal done");
        f0 = frames;
        man_start = 1'b1;
        cyc(1);
        man_start = 1'b0;
        wait_idle;
        chk((frames - f0 == 6) || (frames - f0 == 7), 1);
        chk(direct, {5'h0a, vco_word[4:0]});
        chk(near(vco_word[4:0]), 1);
        chk(cal_cnt[23:0], 24'h000009);
        $display("test manual cal done");
        // polarity mismatch: search drifts to the bottom logical code
        f0 = frames;
        invert = 1'b1;
        man_start = 1'b1;
        cyc(1);
        man_start = 1'b0;
        wait_idle;
        chk(frames - f0, 7);
        chk(cal_res, 24'h00000f);
        chk(vco_word[4:0], 5'h0f);
        chk(direct, 24'h00014f);
        $display("test inverted cal done");
        summarize;
    end
endmodule // fcva_top_tb_top
`default_nettype wire
